// [design/mbr_mdio_regs.sv]
// Management register bank with its serial management frame engine
// Behaviour
// - Writes to a pin-forced bit are dropped
// - Forced bit reverts to its held value
// - Reset bit ORs pin; one resets everything
// - Reset bit reads one, clears next MDC
// - Bit 14 loops back all four channels
// - Bit 11 powers down, ORed with enable low
// - Speed selection bits 13, 6 read one
// - Bits 12, 10, 9, 7 read zero
// - Duplex bit reads one, writes dropped
// - Status unused bits and jabber read zero
// - Status bit 8 reads one
// - Status bit 0 reads one
// - Link bit latches low until read
// - Identifier registers hold fixed vendor codes
// - Register 2 holds identifier bits 3-18
// - Register 3: identifier, model, revision
// - Device 4 or 5 (by DEV_ADDR0) vendor tail registers provided
// - Device 4 or 5 registers above 32781 unimplemented
// - Invalid or read-only writes are dropped
// - Invalid register reads zero; foreign device silent
`timescale 1ns/1ps
module mbr_mdio_regs #(
    parameter logic [15:0] OUI_BITS_3_18 = 16'h2a5c,  // Arbitrary value
    parameter logic [5:0] OUI_BITS_19_24 = 6'h15,     // Arbitrary value
    parameter logic [5:0] MODEL_NUMBER = 6'h0b,       // Arbitrary value
    parameter logic [3:0] REVISION_NUMBER = 4'h3      // Arbitrary value
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic MDC,
    input wire logic MDIO_IN,
    output logic MDIO_OUT,
    output logic MDIO_OE,
    input wire logic [mbr_pkg::PHYAD_W-1:0] PORT_ADDR,
    input wire logic DEV_ADDR0,
    input wire logic ACTIVE_LOW_RESET_PIN_N,
    input wire logic ENABLE,
    input wire logic LINK_UP,
    input wire logic [mbr_pkg::WORD_W-1:0] CHAN_STATUS,
    input wire logic [mbr_pkg::WORD_W-1:0] SYNC_STATUS,
    input wire logic [mbr_pkg::WORD_W-1:0] CLOCK_TOLERANCE_COMPENSATION_STATUS,
    input wire logic [mbr_pkg::WORD_W-1:0] ERR_COUNT_A,
    input wire logic [mbr_pkg::WORD_W-1:0] ERR_COUNT_B,
    input wire logic [mbr_pkg::WORD_W-1:0] ERR_COUNT_C,
    input wire logic [mbr_pkg::WORD_W-1:0] ERR_COUNT_D,
    output logic GLOBAL_RESET,
    output logic LOOPBACK,
    output logic POWER_DOWN,
    output logic [mbr_pkg::WORD_W-1:0] ERR_CNT_CTRL
);
    import mbr_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    mbr_state_t state;             // Frame engine state
    logic mdc_q;                   // MDC one cycle ago
    logic bit_q;                   // Last sampled MDIO bit
    logic [4:0] cnt;               // Bit index within the frame
    logic [HDR_W-2:0] hdr;         // Header bits gathered so far
    logic [WORD_W-1:0] wsh;        // Write data being gathered
    logic [WORD_W-1:0] rsh;        // Read data being sent
    logic is_rd;                   // Frame reads
    logic is_wr;                   // Frame writes
    logic is_addr;                 // Frame loads the extended address
    logic is_inc;                  // Frame reads then increments
    logic is_ext;                  // Frame uses the extended space
    logic [4:0] reg_num;           // Direct register number
    logic [WORD_W-1:0] ext_addr;   // Extended register address
    logic link_lat;                // Latched-low link status
    logic rst_stored;              // Stored reset bit
    logic pd_stored;               // Stored power-down bit

    // ****************************************************************
    // Edge detection and header decode
    // ****************************************************************
    wire mdc_rise = MDC & ~mdc_q;                         // Sampling edge of MDC
    wire [HDR_W-1:0] next_hdr = {hdr, MDIO_IN};           // Full header at last bit
    wire [1:0] h_st = next_hdr[13:12];                    // Start field
    wire [1:0] h_op = next_hdr[11:10];                    // Opcode field
    wire [4:0] h_pa = next_hdr[9:5];                      // Port address field
    wire [4:0] h_ra = next_hdr[4:0];                      // Register or device field
    wire port_hit = (h_pa == PORT_ADDR);                  // Frame is for this port
    wire dev_hit = (h_ra == {DEV_UPPER, DEV_ADDR0});      // Valid extended device
    wire base_hit = port_hit & (h_st == ST_BASE);         // Direct frame for us
    wire ext_hit = port_hit & (h_st == ST_EXT) & dev_hit;
    wire hdr_done = mdc_rise & (state == ST_HDR) & (cnt == BIT_HDR_LAST);
    wire in_data = mdc_rise & (state == ST_DATA);         // Edge inside our frame
    wire at_ta = in_data & (cnt == BIT_TA_FIRST);         // Turnaround edge
    wire at_end = in_data & (cnt == BIT_LAST);            // Last data edge
    wire [WORD_W-1:0] wdata = {wsh[14:0], MDIO_IN};       // Completed write word

    // Write and status-read strobes; writes elsewhere and to read-only registers fall away
    wire wr_ctrl = at_end & is_wr & ~is_ext & (reg_num == REG_BASIC_CONTROL);
    wire wr_errctl = at_end & is_wr & is_ext & (ext_addr == VREG_ERR_CTRL);
    wire rd_status = at_ta & is_rd & ~is_ext & (reg_num == REG_BASIC_STATUS);

    // ****************************************************************
    // Effective control bits and read values
    // ****************************************************************
    wire rst_force = ~ACTIVE_LOW_RESET_PIN_N;             // Reset pin low forces the bit
    wire pd_force = ~ENABLE;                              // Enable low forces power-down
    wire rst_eff = rst_stored | rst_force;
    wire pd_eff = pd_stored | pd_force;
    // Fixed bits read as constants; reserved low six bits read zero
    wire [WORD_W-1:0] ctrl_rd = {rst_eff, LOOPBACK, 1'b1, 1'b0, pd_eff, 1'b0, 1'b0,
                                 1'b1, 1'b0, 1'b1, 6'h00};
    wire [WORD_W-1:0] stat_rd = {7'h00, 1'b1, 1'b0, 4'h0, link_lat, 1'b0,
                                 1'b1};
    wire [WORD_W-1:0] id_high = OUI_BITS_3_18;
    wire [WORD_W-1:0] id_low = {OUI_BITS_19_24, MODEL_NUMBER, REVISION_NUMBER};
    // Direct register space; unused numbers read zero
    wire [WORD_W-1:0] base_rd =
        (reg_num == REG_BASIC_CONTROL) ? ctrl_rd :
        (reg_num == REG_BASIC_STATUS) ? stat_rd :
        (reg_num == REG_IDENTIFIER_HIGH) ? id_high :
        (reg_num == REG_IDENTIFIER_LOW) ? id_low : 16'h0000;
    // Extended vendor tail; reserved and higher numbers read zero
    wire [WORD_W-1:0] ext_rd =
        (ext_addr == VREG_CHAN_STATUS) ? CHAN_STATUS :
        (ext_addr == VREG_SYNC_STATUS) ? SYNC_STATUS :
        (ext_addr == VREG_CTC_STATUS) ? CLOCK_TOLERANCE_COMPENSATION_STATUS :
        (ext_addr == VREG_ERR_CTRL) ? ERR_CNT_CTRL :
        (ext_addr == VREG_ERR_CNT_A) ? ERR_COUNT_A :
        (ext_addr == VREG_ERR_CNT_B) ? ERR_COUNT_B :
        (ext_addr == VREG_ERR_CNT_C) ? ERR_COUNT_C :
        (ext_addr == VREG_ERR_CNT_D) ? ERR_COUNT_D : 16'h0000;
    wire [WORD_W-1:0] rd_word = is_ext ? ext_rd : base_rd; // Word sent on a read

    // ****************************************************************
    // Stored control bits
    // ****************************************************************
    // Reset bit: set by reset or write, dropped on the next MDC edge
    mbr_forced_bit #(
        .RST_VAL(RESET_BIT_RST)
    ) u_reset_bit (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .force_on(rst_force),
        .wr_en(wr_ctrl),
        .wr_val(wdata[CTRL_RESET_BIT]),
        .clr(mdc_rise),
        .stored(rst_stored)
    );

    // Power-down bit: plain storage under the enable pin override
    mbr_forced_bit #(
        .RST_VAL(POWER_DOWN_RST)
    ) u_power_down_bit (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .force_on(pd_force),
        .wr_en(wr_ctrl),
        .wr_val(wdata[CTRL_POWER_DOWN_BIT]),
        .clr(1'b0),
        .stored(pd_stored)
    );

    // ****************************************************************
    // Control outputs
    // ****************************************************************
    // Loopback bit, effective reset and power-down, error counter control
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            LOOPBACK <= LOOPBACK_RST;
            GLOBAL_RESET <= 1'b1;                         // Held in reset while reset is low
            POWER_DOWN <= POWER_DOWN_RST;
            ERR_CNT_CTRL <= ERR_CTRL_RST;
        end
        else
        begin
            if (wr_ctrl)
                LOOPBACK <= wdata[CTRL_LOOPBACK_BIT];
            GLOBAL_RESET <= rst_eff;
            POWER_DOWN <= pd_eff;
            if (wr_errctl)
                ERR_CNT_CTRL <= wdata;
        end
    end

    // ****************************************************************
    // Link status latch
    // ****************************************************************
    // Holds low after a drop; a status read rearms it to the live link
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            link_lat <= LINK_LATCH_RST;
        else if (rd_status)
            link_lat <= LINK_UP;
        else
            link_lat <= link_lat & LINK_UP;
    end

    // ****************************************************************
    // Frame engine
    // ****************************************************************
    // Samples MDIO on each MDC rise, decodes, answers or stores
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            state <= ST_IDLE;
            mdc_q <= 1'b0;
            bit_q <= 1'b0;
            cnt <= 5'h00;
            hdr <= 13'h0000;
            wsh <= 16'h0000;
            rsh <= 16'h0000;
            is_rd <= 1'b0;
            is_wr <= 1'b0;
            is_addr <= 1'b0;
            is_inc <= 1'b0;
            is_ext <= 1'b0;
            reg_num <= 5'h00;
            ext_addr <= EXT_ADDR_RST;
            MDIO_OUT <= 1'b0;
            MDIO_OE <= 1'b0;
        end
        else
        begin
            mdc_q <= MDC;
            if (mdc_rise)
            begin
                bit_q <= MDIO_IN;
                cnt <= cnt + 5'h01;
                case (state)
                    // Start: a zero after a one opens a frame
                    ST_IDLE:
                    begin
                        cnt <= 5'h01;
                        hdr <= {12'h000, MDIO_IN};
                        if (bit_q && !MDIO_IN)
                            state <= ST_HDR;
                    end
                    // Header: gather, then decide whether to take part
                    ST_HDR:
                    begin
                        hdr <= next_hdr[HDR_W-2:0];
                        if (cnt == BIT_HDR_LAST)
                        begin
                            is_ext <= (h_st == ST_EXT);
                            reg_num <= h_ra;
                            is_rd <= base_hit ? (h_op == OP_BASE_RD) :
                                     ((h_op == OP_EXT_RD) || (h_op == OP_EXT_RDINC));
                            is_wr <= base_hit ? (h_op == OP_BASE_WR) : (h_op == OP_EXT_WR);
                            is_addr <= ext_hit & (h_op == OP_EXT_ADDR);
                            is_inc <= ext_hit & (h_op == OP_EXT_RDINC);
                            // Foreign port or device: stay silent to the end
                            state <= (base_hit || ext_hit) ? ST_DATA : ST_SKIP;
                        end
                    end
                    // Turnaround and data bits of our own frame
                    ST_DATA:
                    begin
                        wsh <= wdata;
                        if (cnt == BIT_TA_FIRST)
                        begin
                            // Drive the second turnaround bit low, then data
                            MDIO_OUT <= 1'b0;
                            MDIO_OE <= is_rd;
                            rsh <= rd_word;
                        end
                        else if (cnt == BIT_LAST)
                        begin
                            MDIO_OE <= 1'b0;
                            MDIO_OUT <= 1'b0;
                            state <= ST_IDLE;
                            if (is_addr)
                                ext_addr <= wdata;
                            else if (is_inc)
                                ext_addr <= ext_addr + 16'h0001;
                        end
                        else
                        begin
                            MDIO_OUT <= is_rd & rsh[WORD_W-1];
                            rsh <= {rsh[WORD_W-2:0], 1'b0};
                        end
                    end
                    // Not ours: wait out the frame
                    ST_SKIP:
                    begin
                        if (cnt == BIT_LAST)
                            state <= ST_IDLE;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    forced_pd_hold_a: assert property (pd_force && wr_ctrl |=> $stable(pd_stored))
        else $error("power-down bit changed by a write while forced");
    forced_revert_a: assert property (pd_force ##1 !pd_force |-> pd_stored == $past(pd_stored, 2))
        else $error("forced bit did not return to its held value");
    reset_pin_a: assert property (!ACTIVE_LOW_RESET_PIN_N |=> GLOBAL_RESET)
        else $error("reset pin did not reach the global reset");
    reset_selfclr_a: assert property (rst_stored && mdc_rise && !wr_ctrl && !rst_force |=> !rst_stored)
        else $error("reset bit did not clear on the next MDC edge");
    loopback_write_a: assert property (wr_ctrl |=> LOOPBACK == $past(wdata[CTRL_LOOPBACK_BIT]))
        else $error("loopback did not take the written value");
    enable_pd_a: assert property (!ENABLE |=> POWER_DOWN)
        else $error("enable low did not force power-down");
    ctrl_fixed_a: assert property (ctrl_rd[13:6] == {1'b1, 1'b0, pd_eff, 5'b00101})
        else $error("fixed control bits read wrong");
    status_fixed_a: assert property (stat_rd[15:8] == 8'h01 && stat_rd[1:0] == 2'b01)
        else $error("fixed status bits read wrong");
    link_latch_a: assert property (!LINK_UP || (!link_lat && !rd_status) |=> !link_lat)
        else $error("link drop not latched low");
    turnaround_a: assert property (at_ta && is_rd |=> MDIO_OE && !MDIO_OUT)
        else $error("read turnaround not driven low");
    skip_silent_a: assert property (state == ST_SKIP |-> !MDIO_OE)
        else $error("drove MDIO for a foreign frame");

endmodule

// [design/mbr_pkg.sv]
// Shared constants for the management register bank and its serial frame engine
package mbr_pkg;

    // ****************************************************************
    // Frame field widths and bit positions
    // ****************************************************************
    localparam int PHYAD_W = 5;                  // Port address width
    localparam int WORD_W = 16;                  // Register data width
    localparam int HDR_W = 14;                   // Start, opcode, port and register fields
    localparam logic [4:0] BIT_HDR_LAST = 5'h0d; // Last header bit of a frame
    localparam logic [4:0] BIT_TA_FIRST = 5'h0e; // First turnaround bit
    localparam logic [4:0] BIT_LAST = 5'h1f;     // Last data bit of a frame

    // ****************************************************************
    // Start and opcode encodings
    // ****************************************************************
    localparam logic [1:0] ST_BASE = 2'h1;      // Direct register space frame
    localparam logic [1:0] ST_EXT = 2'h0;       // Extended register space frame
    localparam logic [1:0] OP_BASE_WR = 2'h1;   // Direct write
    localparam logic [1:0] OP_BASE_RD = 2'h2;   // Direct read
    localparam logic [1:0] OP_EXT_ADDR = 2'h0;  // Extended address load
    localparam logic [1:0] OP_EXT_WR = 2'h1;    // Extended write
    localparam logic [1:0] OP_EXT_RDINC = 2'h2; // Extended read then increment
    localparam logic [1:0] OP_EXT_RD = 2'h3;    // Extended read

    // ****************************************************************
    // Register numbers
    // ****************************************************************
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] REG_IDENTIFIER_HIGH = 5'h02;
    localparam logic [4:0] REG_IDENTIFIER_LOW = 5'h03;
    localparam logic [3:0] DEV_UPPER = 4'h2;          // Fixed upper device address bits
    localparam logic [15:0] VREG_RESERVED = 16'h8005; // Reserved, reads zero
    localparam logic [15:0] VREG_CHAN_STATUS = 16'h8006;
    localparam logic [15:0] VREG_SYNC_STATUS = 16'h8007;
    localparam logic [15:0] VREG_CTC_STATUS = 16'h8008;
    localparam logic [15:0] VREG_ERR_CTRL = 16'h8009;
    localparam logic [15:0] VREG_ERR_CNT_A = 16'h800a;
    localparam logic [15:0] VREG_ERR_CNT_B = 16'h800b;
    localparam logic [15:0] VREG_ERR_CNT_C = 16'h800c;
    localparam logic [15:0] VREG_ERR_CNT_D = 16'h800d;

    // ****************************************************************
    // Control field positions
    // ****************************************************************
    localparam int CTRL_RESET_BIT = 15;
    localparam int CTRL_LOOPBACK_BIT = 14;
    localparam int CTRL_POWER_DOWN_BIT = 11;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic RESET_BIT_RST = 1'b1;       // Reset bit reads one after reset
    localparam logic LOOPBACK_RST = 1'b0;
    localparam logic POWER_DOWN_RST = 1'b0;
    localparam logic LINK_LATCH_RST = 1'b0;
    localparam logic [15:0] ERR_CTRL_RST = 16'h0000;
    localparam logic [15:0] EXT_ADDR_RST = 16'h0000;

    // Frame engine states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_SKIP = 4'b1000
    } mbr_state_t;

endpackage

// [design/mbr_forced_bit.sv]
// One stored control bit that a pin condition can force on
`timescale 1ns/1ps
module mbr_forced_bit #(
    parameter logic RST_VAL = 1'b0 // Value after reset
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic force_on,     // Pin condition overriding the bit
    input wire logic wr_en,        // Management write strobe
    input wire logic wr_val,       // Written value
    input wire logic clr,          // Self-clear request
    output logic stored            // Value kept under the override
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    // Stored value is frozen while forced, so it is there again afterwards
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            stored <= RST_VAL;
        else if (force_on)
            stored <= stored;
        else if (wr_en)
            stored <= wr_val;
        else if (clr)
            stored <= 1'b0;
    end

endmodule

// [tb/mbr_station.sv]
// Station management model that clocks frames over the serial pins
`timescale 1ns/1ps
module mbr_station (
    input wire logic clk,
    input wire logic oe,
    input wire logic dout,
    output logic mdc,
    output logic mdio
);
    logic st_oe = 1'b1; // Station drives the wire
    logic st_d = 1'b1; // Station data bit
    // Wire level: device, station, else the pull-up
    assign mdio = oe ? dout : (st_oe ? st_d : 1'b1);
    initial mdc = 1'b0;
    // One frame after two preamble ones, MDC low and high two cycles each
    task automatic frame(input logic [31:0] f, input logic rd, output logic [15:0] q);
        for (int i = -2; i < 32; i++)
        begin
            @(negedge clk);
            mdc = 1'b0;
            st_oe = !(rd && i >= 14);
            st_d = (i < 0) ? 1'b1 : f[31-i];
            @(negedge clk);
            // Read data stands until the next MDC rise
            if (i >= 16) q = {q[14:0], mdio};
            @(negedge clk);
            mdc = 1'b1;
            @(negedge clk);
        end
    endtask
endmodule

// [tb/mbr_mdio_regs_tb.sv]
// Self-checking bench for the management register bank
`timescale 1ns/1ps
module mbr_mdio_regs_tb;
    import mbr_pkg::*;
    logic SYS_CLK = 0, RST_N = 0, pin_n = 1, ENABLE = 1, LINK_UP = 1, dev = 1;
    logic dev_pin = 1; // Low device address bit strapped on the block
    logic [4:0] pa = 5'h0b; // Port address used in frames
    logic [15:0] sts [3]; // Channel, sync, compensation status
    logic [15:0] cnt [4]; // Error counts
    logic [15:0] q, v;
    logic mdc, mdio, oe, dout, grst, lpb, pdn;
    logic [15:0] ectl;
    int n_errors = 0, checked = 0, cycles = 0;
    int model_q[$]; // Expected sweep values
    mbr_station st (.clk(SYS_CLK), .oe(oe), .dout(dout), .mdc(mdc), .mdio(mdio));
    mbr_mdio_regs #(.OUI_BITS_3_18(16'h1234), .OUI_BITS_19_24(6'h2d), .MODEL_NUMBER(6'h07),
        .REVISION_NUMBER(4'h9)) dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .MDC(mdc),
        .MDIO_IN(mdio), .MDIO_OUT(dout), .MDIO_OE(oe), .PORT_ADDR(5'h0b), .DEV_ADDR0(dev_pin),
        .ACTIVE_LOW_RESET_PIN_N(pin_n), .ENABLE(ENABLE), .LINK_UP(LINK_UP),
        .CHAN_STATUS(sts[0]), .SYNC_STATUS(sts[1]), .CLOCK_TOLERANCE_COMPENSATION_STATUS(sts[2]),
        .ERR_COUNT_A(cnt[0]), .ERR_COUNT_B(cnt[1]), .ERR_COUNT_C(cnt[2]),
        .ERR_COUNT_D(cnt[3]), .GLOBAL_RESET(grst), .LOOPBACK(lpb), .POWER_DOWN(pdn),
        .ERR_CNT_CTRL(ectl));
    initial forever #2 SYS_CLK = ~SYS_CLK;
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Direct frames
    task automatic rd(input logic [4:0] r, input logic [15:0] exp);
        st.frame({ST_BASE, OP_BASE_RD, pa, r, 18'h0}, 1'b1, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [4:0] r, input logic [15:0] d);
        st.frame({ST_BASE, OP_BASE_WR, pa, r, 2'b10, d}, 1'b0, q);
    endtask
    // Extended frame; reads are checked against exp
    task automatic ex(input logic [1:0] op, input logic [15:0] d, input logic [15:0] exp);
        st.frame({ST_EXT, op, pa, DEV_UPPER, dev, 2'b10, d}, op[1], q);
        if (op[1]) chk(q, exp);
    endtask
    task automatic wrap_up();
        $display("errors %0d of %0d checks", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge SYS_CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        v = 16'($urandom(14));
        foreach (sts[i]) sts[i] = 16'($urandom);
        foreach (cnt[i]) cnt[i] = 16'($urandom);
        repeat (4) @(negedge SYS_CLK);
        RST_N = 1;
        @(negedge SYS_CLK);
        chk({15'h0, grst}, 16'h1);
        rd(REG_BASIC_CONTROL, 16'h2140);
        chk({15'h0, grst}, 16'h0);
        wr(REG_BASIC_CONTROL, 16'h7fc0);
        rd(REG_BASIC_CONTROL, 16'h6940);
        chk({14'h0, lpb, pdn}, 16'h3);
        wr(REG_BASIC_CONTROL, 16'h0800);
        ENABLE = 0;
        wr(REG_BASIC_CONTROL, 16'h0000);
        ENABLE = 1;
        rd(REG_BASIC_CONTROL, 16'h2940);
        wr(REG_BASIC_CONTROL, 16'h0000);
        ENABLE = 0;
        rd(REG_BASIC_CONTROL, 16'h2940);
        ENABLE = 1;
        pin_n = 0;
        rd(REG_BASIC_CONTROL, 16'ha140);
        chk({14'h0, grst, pdn}, 16'h2);
        pin_n = 1;
        rd(REG_BASIC_CONTROL, 16'h2140);
        // Written reset bit drives the global reset, then clears on the next MDC rise
        wr(REG_BASIC_CONTROL, 16'h8000);
        @(negedge SYS_CLK);
        chk({15'h0, grst}, 16'h1);
        rd(REG_BASIC_CONTROL, 16'h2140);
        chk({15'h0, grst}, 16'h0);
        rd(REG_BASIC_STATUS, 16'h0101);
        rd(REG_BASIC_STATUS, 16'h0105);
        LINK_UP = 0;
        repeat (3) @(negedge SYS_CLK);
        LINK_UP = 1;
        rd(REG_BASIC_STATUS, 16'h0101);
        rd(REG_BASIC_STATUS, 16'h0105);
        wr(REG_IDENTIFIER_HIGH, 16'hffff);
        rd(REG_IDENTIFIER_HIGH, 16'h1234);
        rd(REG_IDENTIFIER_LOW, 16'hb479);
        rd(5'h07, 16'h0000);
        pa = 5'h0c;
        rd(REG_BASIC_STATUS, 16'hffff);
        pa = 5'h0b;
        ex(OP_EXT_ADDR, VREG_ERR_CTRL, 16'h0);
        ex(OP_EXT_WR, v, 16'h0);
        chk(ectl, v);
        ex(OP_EXT_RD, 16'h0, v);
        foreach (sts[i]) model_q.push_back(sts[i]);
        model_q.push_back(v);
        foreach (cnt[i]) model_q.push_back(cnt[i]);
        ex(OP_EXT_ADDR, VREG_CHAN_STATUS, 16'h0);
        while (model_q.size() > 0) ex(OP_EXT_RDINC, 16'h0, 16'(model_q.pop_front()));
        ex(OP_EXT_RD, 16'h0, 16'h0);
        ex(OP_EXT_ADDR, VREG_RESERVED, 16'h0);
        ex(OP_EXT_RD, 16'h0, 16'h0);
        dev = 0;
        ex(OP_EXT_RD, 16'h0, 16'hffff);
        // Strap low: the lower device now answers
        dev_pin = 0;
        ex(OP_EXT_ADDR, VREG_ERR_CTRL, 16'h0);
        ex(OP_EXT_RD, 16'h0, v);
        wrap_up();
    end
endmodule
